// file: include/css_defines.svh
/*
 * offsets, field positions, reset values and masks of the core status
 * word and the system register space.
 * assumes: included by bare name from the package file.
 */
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH

// ****************************************************************
// system register byte addresses (four times the register number)
// ****************************************************************
`define CSS_AW           10
`define CSS_ADDR_SR      10'h000
`define CSS_ADDR_EXCEPTION_VECTOR_BASE    10'h004
`define CSS_ADDR_CALL_TABLE_BASE    10'h008
`define CSS_ADDR_CTRL    10'h00c
`define CSS_ADDR_ECAUSE  10'h010
`define CSS_ADDR_DBG_RS  10'h030
`define CSS_ADDR_DBG_RA  10'h050
`define CSS_ADDR_CFG0    10'h100
`define CSS_ADDR_CFG1    10'h104
`define CSS_ADDR_COUNT   10'h108
`define CSS_ADDR_MATCH   10'h10c

// ****************************************************************
// status word bit positions
// ****************************************************************
`define CSS_B_SS   31
`define CSS_B_DM   27
`define CSS_B_D    26
`define CSS_B_M2   24
`define CSS_B_M0   22
`define CSS_B_EM   21
`define CSS_B_I0M  17
`define CSS_B_GM   16
`define CSS_B_T    14
`define CSS_B_L    5
`define CSS_B_Q    4
`define CSS_B_V    3
`define CSS_B_N    2
`define CSS_B_Z    1
`define CSS_B_C    0

// ****************************************************************
// reset values and write masks
// ****************************************************************
`define CSS_SR_RESET     32'h0061_0000
`define CSS_SR_SW_MASK   32'h083f_403f
`define CSS_SR_LOW_MASK  32'h0000_403f
`define CSS_CTRL_MASK    32'h0003_ffc0
`define CSS_CTRL_RESET   32'h0000_8400
`define CSS_B_NOCLR      17

// ****************************************************************
// execution mode encodings
// ****************************************************************
`define CSS_MODE_APP     3'h0
`define CSS_MODE_SUP     3'h1
`define CSS_MODE_IRQ_LEVEL_ZERO    3'h2
`define CSS_MODE_EXC     3'h6
`define CSS_MODE_NMI     3'h7

`endif

// file: include/css_pkg.sv
/*
 * types shared by the status and system register files.
 * assumes: css_defines.svh on the include path.
 */
`include "css_defines.svh"

package css_pkg;
    typedef logic [31:0]          css_word_t;
    typedef logic [`CSS_AW-1:0]   css_addr_t;
    typedef logic [2:0]           css_mode_t;
endpackage : css_pkg

// file: core/css_word_reg.sv
/*
 * one 32-bit system register with a software write port and a
 * hardware load port; a hardware load wins over a software write.
 * assumes: both strobes come from logic on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module css_word_reg
    import css_pkg::*;
#(
    parameter css_word_t RESET_VALUE = 32'h0000_0000
) (
    input  wire logic      clk_sys,
    input  wire logic      arst_n,
    input  wire logic      sw_we,
    input  wire css_word_t sw_data,
    input  wire logic      hw_we,
    input  wire css_word_t hw_data,
    output css_word_t      value
);

    // hardware capture takes precedence over software
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            value <= RESET_VALUE;
        end else if (hw_we) begin
            value <= hw_data;
        end else if (sw_we) begin
            value <= sw_data;
        end
    end

endmodule : css_word_reg

`default_nettype wire

// file: core/css_cycle_count.sv
/*
 * free running cycle counter with a match value; on a match the
 * counter is cleared unless the no-clear control bit is set.
 * assumes: write strobes come from logic on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module css_cycle_count
    import css_pkg::*;
(
    input  wire logic      clk_sys,
    input  wire logic      arst_n,
    input  wire logic      count_we,
    input  wire logic      match_we,
    input  wire css_word_t wdata,
    input  wire logic      no_clear,
    output css_word_t      count,
    output css_word_t      match_value,
    output logic           match_hit
);

    // a zero match value means disabled, so reset state never fires
    wire hit = (count == match_value) && (match_value != 32'h0000_0000);

    // counter: software load beats the match clear
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count <= 32'h0000_0000;
        end else if (count_we) begin
            count <= wdata;
        end else if (hit && !no_clear) begin
            count <= 32'h0000_0000;
        end else begin
            count <= count + 32'h0000_0001;
        end
    end

    // match value and a one cycle hit pulse
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            match_value <= 32'h0000_0000;
            match_hit   <= 1'b0;
        end else begin
            match_hit <= hit;
            if (match_we) begin
                match_value <= wdata;
            end
        end
    end

endmodule : css_cycle_count

`default_nettype wire

// file: core/css_sysregs.sv
/*
 * status word and system register space of the processor core:
 * mode, masks and flags, driven by pipeline events and by the
 * privileged move-to / move-from system register port.
 * assumes: every input comes from core logic on clk_sys; event
 * strobes are one-cycle pulses; at most one of the entry/return
 * events is raised per cycle (priority below resolves collisions).
 */
// How it works
// - debug entry block set means debug requests are ignored; software rw.
// - debug-active bit set only by debug entry, cleared by retd.
// - three mode bits encode nmi, exception, irq levels, supervisor, app.
// - reset puts the mode field to supervisor.
// - mode follows interrupt, exception, scall, rets, rete; writes ignored.
// - exception block set at reset, exception and debug entry; sw clears.
// - level 3 enabled when its block and global block clear.
// - level 2 block set on level 3 or 2 entry; cleared at reset.
// - level 1 block set on level 3, 2 or 1 entry; cleared at reset.
// - level 0 block set on any interrupt entry; cleared at reset.
// - global block overrides all levels; set reset/exc/debug/java trap.
// - scratch flag changed by software writes, flag ops and status restores; cleared at reset.
// - lock flag cleared by rete and at reset.
// - saturation flag sticky until software clears it.
// - alu results update overflow, negative, zero and carry flags.
// - registers reached only via the privileged system register port.
// - byte address is four times the register number.
// - debug return status at 48 and debug return address at 80.
// - upper status half accessible only from a privileged mode.
// - secure-state bit reads zero unless secure state is implemented.
`timescale 1ns/1ps
`default_nettype none

module css_sysregs
    import css_pkg::*;
#(
    parameter logic      SECURE_IMPL = 1'b0,
    parameter css_word_t CFG0_VALUE  = 32'h0000_0000, // arbitrary
    parameter css_word_t CFG1_VALUE  = 32'h0000_0000  // arbitrary
) (
    input  wire logic      clk_sys,
    input  wire logic      arst_n,
    // system register port (move-to / move-from)
    input  wire logic      sysreg_rd,
    input  wire logic      sysreg_wr,
    input  wire css_addr_t sysreg_addr,
    input  wire css_word_t sysreg_wdata,
    output css_word_t      sysreg_rdata,
    output logic           sysreg_rvalid,
    // pipeline events
    input  wire logic      irq_start,
    input  wire logic [1:0] irq_level,
    input  wire logic      exc_start,
    input  wire css_word_t exc_code,
    input  wire logic      nmi_start,
    input  wire logic      dbg_req,
    input  wire logic      bkpt_exec,
    input  wire logic      retd_exec,
    input  wire logic      scall_exec,
    input  wire logic      rets_exec,
    input  wire logic      rete_exec,
    input  wire css_word_t ret_status,
    input  wire css_word_t pc_value,
    input  wire logic      java_trap,
    input  wire logic      java_return,
    input  wire logic      secure_state,
    // flag updates
    input  wire logic      alu_flag_we,
    input  wire logic      alu_v,
    input  wire logic      alu_n,
    input  wire logic      alu_z,
    input  wire logic      alu_c,
    input  wire logic      sat_ovf,
    input  wire logic      flag_set,
    input  wire logic      flag_clr,
    input  wire logic [4:0] flag_idx,
    // state toward the core
    output css_word_t      status_word,
    output logic [3:0]     irq_enable,
    output logic           exc_enable,
    output logic           debug_entered,
    output css_word_t      core_control,
    output logic           count_match
);

    // ************************************************************
    // address decode
    // ************************************************************
    css_word_t sr;
    css_word_t next_sr;
    css_word_t exception_vector_base_q;
    css_word_t call_table_base_q;
    css_word_t ecause_q;
    css_word_t dbg_rs_q;
    css_word_t dbg_ra_q;
    css_word_t count_q;
    css_word_t match_q;
    css_word_t ctrl_q;
    logic      hit_q;

    // privilege is anything but application mode
    wire css_mode_t mode_now = sr[`CSS_B_M2:`CSS_B_M0];
    wire priv = (mode_now != `CSS_MODE_APP);

    wire sel_sr     = (sysreg_addr == `CSS_ADDR_SR);
    wire sel_exception_vector_base   = (sysreg_addr == `CSS_ADDR_EXCEPTION_VECTOR_BASE);
    wire sel_call_table_base   = (sysreg_addr == `CSS_ADDR_CALL_TABLE_BASE);
    wire sel_ctrl   = (sysreg_addr == `CSS_ADDR_CTRL);
    wire sel_ecause = (sysreg_addr == `CSS_ADDR_ECAUSE);
    wire sel_dbg_rs = (sysreg_addr == `CSS_ADDR_DBG_RS);
    wire sel_dbg_ra = (sysreg_addr == `CSS_ADDR_DBG_RA);
    wire sel_cfg0   = (sysreg_addr == `CSS_ADDR_CFG0);
    wire sel_cfg1   = (sysreg_addr == `CSS_ADDR_CFG1);
    wire sel_count  = (sysreg_addr == `CSS_ADDR_COUNT);
    wire sel_match  = (sysreg_addr == `CSS_ADDR_MATCH);

    // only the status word is open to application code, low half only
    wire wr_priv = sysreg_wr && priv;
    wire wr_sr   = sysreg_wr && sel_sr;
    wire css_word_t sr_wmask = priv ? `CSS_SR_SW_MASK
                                    : `CSS_SR_LOW_MASK;

    // ************************************************************
    // read data selection
    // ************************************************************
    // secure bit only exists when the option is built in
    wire ss_bit = SECURE_IMPL & secure_state;
    wire css_word_t sr_view = {ss_bit, sr[30:0]};
    wire css_word_t sr_read = priv ? sr_view
                                   : {16'h0000, sr_view[15:0]};

    // unmapped and unused numbers fall through to zero
    wire css_word_t rd_mux =
        sel_sr     ? sr_read :
        !priv      ? 32'h0000_0000 :
        sel_exception_vector_base   ? exception_vector_base_q :
        sel_call_table_base   ? call_table_base_q :
        sel_ctrl   ? ctrl_q :
        sel_ecause ? ecause_q :
        sel_dbg_rs ? dbg_rs_q :
        sel_dbg_ra ? dbg_ra_q :
        sel_cfg0   ? CFG0_VALUE :
        sel_cfg1   ? CFG1_VALUE :
        sel_count  ? count_q :
        sel_match  ? match_q :
                     32'h0000_0000;

    // ************************************************************
    // event qualification
    // ************************************************************
    // a masked or already active debug state refuses entry
    wire dbg_try  = dbg_req || bkpt_exec;
    wire dbg_take = dbg_try && !sr[`CSS_B_DM] && !sr[`CSS_B_D];

    // single-bit flag op: only software-writable bits are touched
    wire css_word_t flag_bit = 32'h0000_0001 << flag_idx;
    wire css_word_t flag_sel = flag_bit & sr_wmask;

    // per-level block pattern for an interrupt entry at irq_level
    wire [3:0] lvl_set = {irq_level == 2'h3,
                          irq_level >= 2'h2,
                          irq_level >= 2'h1,
                          1'b1};

    // ************************************************************
    // next status word
    // ************************************************************
    // software first, then alu flags, then hardware events on top,
    // so that a hardware set always beats a same-cycle clear
    always_comb begin
        next_sr = sr;
        if (wr_sr) begin
            next_sr = (sr & ~sr_wmask)
                    | (sysreg_wdata & sr_wmask);
        end
        if (flag_set) begin
            next_sr = next_sr | flag_sel;
        end
        if (flag_clr) begin
            next_sr = next_sr & ~flag_sel;
        end
        if (alu_flag_we) begin
            next_sr[`CSS_B_V] = alu_v;
            next_sr[`CSS_B_N] = alu_n;
            next_sr[`CSS_B_Z] = alu_z;
            next_sr[`CSS_B_C] = alu_c;
        end
        if (sat_ovf) begin
            next_sr[`CSS_B_Q] = 1'b1;
        end
        if (java_return) begin
            next_sr[`CSS_B_GM] = 1'b0;
        end
        if (java_trap) begin
            next_sr[`CSS_B_GM] = 1'b1;
        end
        // mode transfers, highest priority last
        if (scall_exec) begin
            next_sr[`CSS_B_M2:`CSS_B_M0] = `CSS_MODE_SUP;
        end
        if (rets_exec || rete_exec) begin
            // restored word may not touch the debug-active or secure bit
            next_sr = {1'b0, ret_status[30:27], sr[`CSS_B_D],
                       ret_status[25:0]};
        end
        if (rete_exec) begin
            next_sr[`CSS_B_L] = 1'b0;
        end
        if (irq_start) begin
            next_sr[`CSS_B_M2:`CSS_B_M0] =
                `CSS_MODE_IRQ_LEVEL_ZERO + {1'b0, irq_level};
            next_sr[`CSS_B_I0M+3:`CSS_B_I0M] =
                next_sr[`CSS_B_I0M+3:`CSS_B_I0M] | lvl_set;
        end
        if (exc_start) begin
            next_sr[`CSS_B_M2:`CSS_B_M0] = `CSS_MODE_EXC;
            next_sr[`CSS_B_EM] = 1'b1;
            next_sr[`CSS_B_GM] = 1'b1;
        end
        if (nmi_start) begin
            next_sr[`CSS_B_M2:`CSS_B_M0] = `CSS_MODE_NMI;
        end
        if (retd_exec && sr[`CSS_B_D]) begin
            next_sr = {1'b0, dbg_rs_q[30:27], 1'b0,
                       dbg_rs_q[25:0]};
        end
        if (dbg_take) begin
            next_sr[`CSS_B_D]  = 1'b1;
            next_sr[`CSS_B_EM] = 1'b1;
            next_sr[`CSS_B_GM] = 1'b1;
        end
        next_sr[`CSS_B_SS] = 1'b0;
        next_sr[30:28]     = 3'h0;
        next_sr[25]        = 1'b0;
        next_sr[15]        = 1'b0;
        next_sr[13:6]      = 8'h00;
    end

    // ************************************************************
    // status word register and derived enables
    // ************************************************************
    // enables come from next_sr so they line up with status_word
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sr         <= `CSS_SR_RESET;
            irq_enable <= 4'h0;
            exc_enable <= 1'b0;
        end else begin
            sr         <= next_sr;
            irq_enable <= ~next_sr[`CSS_B_I0M+3:`CSS_B_I0M]
                        & {4{~next_sr[`CSS_B_GM]}};
            exc_enable <= ~next_sr[`CSS_B_EM];
        end
    end

    // status word as seen by the core, secure bit folded in
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            status_word <= `CSS_SR_RESET;
        end else begin
            status_word <= {SECURE_IMPL & secure_state,
                            next_sr[30:0]};
        end
    end

    // ************************************************************
    // read port and event pulses
    // ************************************************************
    // reads answer one cycle later; no wait states, no fault
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sysreg_rdata  <= 32'h0000_0000;
            sysreg_rvalid <= 1'b0;
            debug_entered <= 1'b0;
            count_match   <= 1'b0;
        end else begin
            sysreg_rvalid <= sysreg_rd;
            if (sysreg_rd) begin
                sysreg_rdata <= rd_mux;
            end
            debug_entered <= dbg_take;
            count_match   <= hit_q;
        end
    end

    // ************************************************************
    // control register
    // ************************************************************
    // unused bits stay zero whatever is written
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= `CSS_CTRL_RESET;
        end else if (wr_priv && sel_ctrl) begin
            ctrl_q <= sysreg_wdata & `CSS_CTRL_MASK;
        end
    end

    // registered copy toward the core
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            core_control <= `CSS_CTRL_RESET;
        end else begin
            core_control <= ctrl_q;
        end
    end

    // ************************************************************
    // plain word registers
    // ************************************************************
    css_word_reg u_exception_vector_base (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .sw_we   (wr_priv && sel_exception_vector_base),
        .sw_data (sysreg_wdata),
        .hw_we   (1'b0),
        .hw_data (32'h0000_0000),
        .value   (exception_vector_base_q)
    );

    // call table must stay word aligned; low bits kept as written
    css_word_reg u_call_table_base (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .sw_we   (wr_priv && sel_call_table_base),
        .sw_data (sysreg_wdata),
        .hw_we   (1'b0),
        .hw_data (32'h0000_0000),
        .value   (call_table_base_q)
    );

    // cause is written by the exception entry only
    css_word_reg u_ecause (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .sw_we   (1'b0),
        .sw_data (32'h0000_0000),
        .hw_we   (exc_start),
        .hw_data (exc_code),
        .value   (ecause_q)
    );

    // debug entry snapshots the status word and the return pc
    css_word_reg u_dbg_rs (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .sw_we   (wr_priv && sel_dbg_rs),
        .sw_data (sysreg_wdata),
        .hw_we   (dbg_take),
        .hw_data (sr),
        .value   (dbg_rs_q)
    );

    css_word_reg u_dbg_ra (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .sw_we   (wr_priv && sel_dbg_ra),
        .sw_data (sysreg_wdata),
        .hw_we   (dbg_take),
        .hw_data (pc_value),
        .value   (dbg_ra_q)
    );

    // ************************************************************
    // cycle counter and match
    // ************************************************************
    css_cycle_count u_count (
        .clk_sys     (clk_sys),
        .arst_n      (arst_n),
        .count_we    (wr_priv && sel_count),
        .match_we    (wr_priv && sel_match),
        .wdata       (sysreg_wdata),
        .no_clear    (ctrl_q[`CSS_B_NOCLR]),
        .count       (count_q),
        .match_value (match_q),
        .match_hit   (hit_q)
    );

endmodule : css_sysregs

`default_nettype wire

// file: dv/css_sysregs_sva.sv
/* port checker for css_sysregs.
   assumes: bound to every css_sysregs instance. */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// assertions on the read port and status word outputs
// ****************************************
module css_sysregs_sva
    import css_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       arst_n,
    input wire logic       sysreg_rd,
    input wire logic       sysreg_rvalid,
    input wire logic       irq_start,
    input wire logic [1:0] irq_level,
    input wire logic       exc_start,
    input wire logic       nmi_start,
    input wire logic       dbg_req,
    input wire logic       rete_exec,
    input wire logic       debug_entered,
    input wire css_word_t  status_word,
    input wire logic [3:0] irq_enable,
    input wire logic       exc_enable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // entry masks the entered level and every lower one
    wire logic [3:0] lvl_mask = 4'hf >> (2'd3 - irq_level);

    a_read_answer: assert property (sysreg_rd |=> sysreg_rvalid)
        else $error("read not answered");
    a_rvalid_cause: assert property (sysreg_rvalid |-> $past(sysreg_rd))
        else $error("answer without read");
    a_irq_mode: assert property (irq_start && !exc_start && !nmi_start
        |=> status_word[24:22] == 3'h2 + $past({1'b0, irq_level}))
        else $error("wrong mode after irq entry");
    a_irq_masks: assert property (irq_start
        |=> (status_word[20:17] & $past(lvl_mask)) == $past(lvl_mask))
        else $error("level masks not set on irq entry");
    a_exc_entry: assert property (exc_start && !nmi_start
        |=> status_word[24:21] == 4'hd && status_word[16])
        else $error("exception entry state wrong");
    a_irq_gate: assert property (irq_enable ==
        (~status_word[20:17] & {4{~status_word[16]}}))
        else $error("irq enables disagree with masks");
    a_exc_gate: assert property (exc_enable == !status_word[21])
        else $error("exception enable disagrees");
    a_debug_enter: assert property (dbg_req && status_word[27:26] == 2'b00
        |=> status_word[26] && debug_entered)
        else $error("debug entry missed");
    a_debug_block: assert property (dbg_req && status_word[27:26] == 2'b10
        |=> !status_word[26])
        else $error("debug entered while blocked");
    a_rete_unlock: assert property (rete_exec |=> !status_word[5])
        else $error("lock flag kept after rete");
    c_irq: cover property (irq_start);
    c_exc: cover property (exc_start);
    c_dbg: cover property (debug_entered);
endmodule : css_sysregs_sva

bind css_sysregs css_sysregs_sva i_css_sysregs_sva (.clk_sys, .arst_n,
    .sysreg_rd, .sysreg_rvalid, .irq_start, .irq_level, .exc_start,
    .nmi_start, .dbg_req, .rete_exec, .debug_entered, .status_word,
    .irq_enable, .exc_enable);

`default_nettype wire

// file: dv/css_tb.sv
/* directed bench for css_sysregs through its system register port.
   assumes: checker bound in css_sysregs_sva.sv. */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// bench
// ****************************************
module tb;
    import css_pkg::*;
    logic clk_sys = 0, arst_n = 0, sysreg_rd = 0, sysreg_wr = 0;
    css_addr_t sysreg_addr = '0;
    css_word_t sysreg_wdata = '0, exc_code = '0, ret_status = '0;
    css_word_t pc_value = '0, sysreg_rdata, status_word, core_control;
    logic irq_start = 0, exc_start = 0, nmi_start = 0, dbg_req = 0;
    logic bkpt_exec = 0, retd_exec = 0, scall_exec = 0, rets_exec = 0;
    logic rete_exec = 0, java_trap = 0, java_return = 0, sat_ovf = 0;
    logic alu_flag_we = 0, alu_v = 0, alu_n = 0, alu_z = 0, alu_c = 0;
    logic flag_set = 0, flag_clr = 0, sysreg_rvalid, exc_enable;
    logic debug_entered, count_match, secure_state = 0;
    logic [1:0] irq_level = '0;
    logic [4:0] flag_idx = '0;
    logic [3:0] irq_enable;
    int bad_count = 0, compares = 0;
    // plain, reserved, masked and read-only places
    css_addr_t at[7] = '{10'h004, 10'h008, 10'h00c, 10'h10c,
                         10'h014, 10'h100, 10'h3fc};
    css_word_t mt[7] = '{32'hffff_ffff, 32'hffff_ffff, 32'h0003_ffc0,
                         32'hffff_ffff, 32'h0, 32'h0, 32'h0};

    css_sysregs i_css_sysregs (.clk_sys, .arst_n, .sysreg_rd, .sysreg_wr,
        .sysreg_addr, .sysreg_wdata, .sysreg_rdata, .sysreg_rvalid,
        .irq_start, .irq_level, .exc_start, .exc_code, .nmi_start, .dbg_req,
        .bkpt_exec, .retd_exec, .scall_exec, .rets_exec, .rete_exec,
        .ret_status, .pc_value, .java_trap, .java_return,
        .secure_state, .alu_flag_we, .alu_v, .alu_n, .alu_z, .alu_c,
        .sat_ovf, .flag_set, .flag_clr, .flag_idx, .status_word,
        .irq_enable, .exc_enable, .debug_entered, .core_control,
        .count_match);

    always #5 clk_sys = ~clk_sys;

    task automatic chk(string what, css_word_t exp, css_word_t got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    // one-cycle strobe, then the status word it leaves
    task automatic ev(ref logic s, input css_word_t exp);
        @(negedge clk_sys) s = 1'b1;
        @(negedge clk_sys) s = 1'b0;
        chk("status", exp, status_word);
    endtask : ev

    task automatic wr(css_addr_t a, css_word_t d);
        @(negedge clk_sys);
        sysreg_addr = a;
        sysreg_wdata = d;
        sysreg_wr = 1'b1;
        @(negedge clk_sys) sysreg_wr = 1'b0;
    endtask : wr

    task automatic rd(css_addr_t a, css_word_t exp);
        @(negedge clk_sys);
        sysreg_addr = a;
        sysreg_rd = 1'b1;
        @(negedge clk_sys) sysreg_rd = 1'b0;
        chk("rvalid", 32'h1, {31'h0, sysreg_rvalid});
        chk("rdata", exp, sysreg_rdata);
    endtask : rd

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    // a hang costs far more than the 126 cycles of the run
    initial begin
        #50us;
        bad_count++;
        conclude();
    end

    initial begin
        repeat (2) @(negedge clk_sys);
        arst_n = 1'b1;
        chk("status", 32'h0061_0000, status_word);
        chk("control", 32'h0000_8400, core_control);
        chk("enables", 32'h0, {irq_enable, exc_enable});
        wr(10'h000, 32'hffff_ffff);
        chk("status", 32'h087f_403f, status_word);
        wr(10'h000, 32'h0);
        chk("enables", 32'h1f, {irq_enable, exc_enable});
        irq_level = 2'd2;
        ev(irq_start, 32'h010e_0000);
        chk("enables", 32'h11, {irq_enable, exc_enable});
        exc_code = 32'h0000_0011;
        ev(exc_start, 32'h01af_0000);
        rd(10'h010, 32'h0000_0011);
        ev(nmi_start, 32'h01ef_0000);
        ret_status = 32'h0000_0020;
        ev(rete_exec, 32'h0);
        flag_idx = 5'd14;
        ev(flag_set, 32'h0000_4000);
        wr(10'h000, 32'hffff_ffff);
        rd(10'h000, 32'h0000_403f);
        wr(10'h004, 32'h0000_5a5a);
        rd(10'h004, 32'h0);
        ev(scall_exec, 32'h0040_403f);
        wr(10'h000, 32'h0);
        {alu_v, alu_z, alu_c} = 3'b111;
        ev(sat_ovf, 32'h0040_0010);
        ev(alu_flag_we, 32'h0040_001b);
        flag_idx = 5'd4;
        ev(flag_clr, 32'h0040_000b);
        ev(java_trap, 32'h0041_000b);
        chk("enables", 32'h01, {irq_enable, exc_enable});
        ev(java_return, 32'h0040_000b);
        wr(10'h000, 32'h0800_0000);
        ev(dbg_req, 32'h0840_0000);
        wr(10'h000, 32'h0);
        pc_value = 32'h0000_1234;
        ev(dbg_req, 32'h0461_0000);
        ev(bkpt_exec, 32'h0461_0000);
        rd(10'h030, 32'h0040_0000);
        rd(10'h050, 32'h0000_1234);
        ev(retd_exec, 32'h0040_0000);
        foreach (at[i]) begin
            wr(at[i], 32'hffff_ffff);
            rd(at[i], mt[i]);
        end
        chk("control", 32'h0003_ffc0, core_control);
        secure_state = 1'b1;
        rd(10'h000, 32'h0040_0000);
        wr(10'h10c, 32'h0000_0020);
        wr(10'h108, 32'h0);
        repeat (33) @(negedge clk_sys);
        chk("match", 32'h0, {31'h0, count_match});
        @(negedge clk_sys);
        chk("match", 32'h1, {31'h0, count_match});
        ev(rets_exec, 32'h0000_0020);
        conclude();
    end
endmodule : tb

`default_nettype wire
